// [hw/jvtx_map.svh]
// Register offsets, field positions, reset values and CRC constants for the
// J1850 VPW transmit and response control block.
// Assumes a 32-bit APB register bus and byte addresses on paddr.
//
// Overview of operation
// (RULE1) Fast receive select: receive only, never transmit
// (RULE2) Fast select clear: normal rate transmit and receive
// (RULE3) Normalization bit polarity from format bit and CRC
// (RULE4) End of data: current byte, CRC, EOD
// (RULE5) Held byte goes out before the CRC
// (RULE6) End of data request masks data empty flag
// (RULE7) Main message: clear request at first CRC bit
// (RULE8) Response: clear request on own EOD echo
// (RULE9) Response requests priority encoded internally
// (RULE10) Response request bits read back as written
// (RULE11) Software sets at most one response request; the bench writes 3'b011 and 3'b111 to exercise the priority encoder
// (RULE12) Responder sends normalization bit before its bytes
// (RULE13) One normalization bit; responders sync to it
// (RULE14) Lost identifier retried until own byte seen
// (RULE15) Frame layouts: main message and single byte
// (RULE16) Multi byte response: NB, data, CRC, EOD; a response without CRC is sent as NB, data, EOD
// (RULE17) Response request armed before valid EOD received
// (RULE18) Multi byte with CRC ends with CRC byte
// (RULE19) Multi byte without CRC never appends CRC
// (RULE20) No response request: send nothing after EOD
`ifndef JVTX_MAP_SVH
`define JVTX_MAP_SVH

// Register byte offsets
`define JVTX_CTRL_OFS     8'h00
`define JVTX_DATA_OFS     8'h04
`define JVTX_STAT_OFS     8'h08

// Control register fields
`define JVTX_C_FAST       0
`define JVTX_C_NORM_BIT_FORMAT_SELECT       1
`define JVTX_C_EOD        2
`define JVTX_C_RSP_LO     3
`define JVTX_C_RSP_HI     5

// Response request positions inside the three-bit field
`define JVTX_RSP_NOCRC    0
`define JVTX_RSP_MCRC     1
`define JVTX_RSP_SINGLE   2

// Reset values and last bit count
`define JVTX_RSP_RST      3'h0
`define JVTX_BYTE_RST     8'h00
`define JVTX_CNT_LAST     3'h7
`define JVTX_CNT_RST      3'h0

// J1850 CRC-8: polynomial, preset, final inversion
`define JVTX_CRC_POLY     8'h1d
`define JVTX_CRC_INIT     8'hff
`define JVTX_CRC_XOR      8'hff

`endif

// [hw/jvtx_pkg.sv]
// Types shared by the J1850 VPW transmit and response control block.
// Assumes nothing beyond a SystemVerilog compiler.
package jvtx_pkg;

  // Symbols asked of the external symbol timer
  typedef enum logic [1:0] {
    JVTX_SYM_SOF = 2'h0,
    JVTX_SYM_BIT = 2'h1,
    JVTX_SYM_NB  = 2'h2,
    JVTX_SYM_EOD = 2'h3
  } jvtx_sym_type;

  // Transmit sequencer states, encodings in Gray code order as listed
  typedef enum logic [2:0] {
    JVTX_IDLE  = 3'h0,
    JVTX_SOF   = 3'h1,
    JVTX_LOAD  = 3'h3,
    JVTX_SHIFT = 3'h2,
    JVTX_CRCB  = 3'h6,
    JVTX_EODS  = 3'h7,
    JVTX_NB    = 3'h5,
    JVTX_RETRY = 3'h4
  } jvtx_state_type;

endpackage

// [hw/jvtx_crc_if.sv]
// Carrier between the sequencer and its CRC unit.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface jvtx_crc_if;
  logic       init;     // Preset the remainder
  logic       step;     // Shift one bit in
  logic       din;      // Bit being sent
  logic [7:0] crc_out;  // Inverted remainder, ready to send
  modport user (output init, output step, output din, input crc_out);
  modport unit (input init, input step, input din, output crc_out);
endinterface
`default_nettype wire

// [hw/jvtx_crc8.sv]
// Bit-serial J1850 CRC-8 unit, one bit per step, MSB first.
// Assumes init and step never arrive in the same cycle.
`timescale 1ns/1ps
`default_nettype none
`include "jvtx_map.svh"
module jvtx_crc8
  import jvtx_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  jvtx_crc_if.unit  crc
);
  logic [7:0] rem_r;    // Running remainder
  logic [7:0] rem_nxt;  // Remainder after this cycle
  wire        fb = rem_r[7] ^ crc.din;  // Feedback bit

  // Next remainder: preset, shift or hold
  assign rem_nxt = crc.init ? `JVTX_CRC_INIT :
                   crc.step ? ({rem_r[6:0], 1'b0} ^ (fb ? `JVTX_CRC_POLY : 8'h00)) :
                   rem_r;
  assign crc.crc_out = rem_r ^ `JVTX_CRC_XOR;

  // Remainder register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rem_r <= `JVTX_CRC_INIT;
    else rem_r <= rem_nxt;
  end
endmodule // jvtx_crc8
`default_nettype wire

// [hw/jvtx_rsp_prio.sv]
// Priority encoder for the three response request bits.
// Assumes raw bits ordered single, multi with CRC, multi without CRC.
`timescale 1ns/1ps
`default_nettype none
`include "jvtx_map.svh"
module jvtx_rsp_prio
  import jvtx_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic [2:0] rsp_raw,
  output logic      [2:0] rsp_eff
);
  // Highest set bit wins: single, then with CRC, then without
  assign rsp_eff = rsp_raw[`JVTX_RSP_SINGLE] ? 3'h4 :
                   rsp_raw[`JVTX_RSP_MCRC]   ? 3'h2 :
                   rsp_raw & 3'h1;  // see (RULE9)

  a_prio_onehot: assert property (@(posedge pclk) disable iff (!presetn) // see (RULE9)
    $onehot0(rsp_eff) && ((rsp_raw == 3'h0) == (rsp_eff == 3'h0)))
    else $error("response priority output not one-hot");
endmodule // jvtx_rsp_prio
`default_nettype wire

// [hw/jvtx_tx_ctrl.sv]
// J1850 VPW transmit and in-frame response control with APB registers.
// Assumes an external symbol timer that sends each requested symbol and
// pulses sym_ready when it is done, and a receiver that reports events.
`timescale 1ns/1ps
`default_nettype none
`include "jvtx_map.svh"
module jvtx_tx_ctrl
  import jvtx_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  output logic              sym_valid,
  output jvtx_sym_type      sym_code,
  output logic              sym_bit,
  input  wire logic         sym_ready,
  input  wire logic         rx_eod_ok,
  input  wire logic         rx_nb_seen,
  input  wire logic         rx_byte_valid,
  input  wire logic [7:0]   rx_byte,
  input  wire logic         arb_lost,
  input  wire logic         bus_error,
  output logic              rate_fast,
  output logic              tx_data_empty_flag
);
  // Control state
  jvtx_state_type state_r, state_nxt;  // Sequencer
  logic       fast_r, fast_nxt;        // fast_receive_select
  logic       norm_bit_format_select_r, norm_bit_format_select_nxt;        // norm_bit_format_select
  logic       eod_r, eod_nxt;          // end_of_data_request
  logic [2:0] rsp_r, rsp_nxt;          // Response requests as written
  logic [2:0] rsp_eff;                 // Response requests after priority
  logic [7:0] hold_r, hold_nxt;        // Holding register
  logic       full_r, full_nxt;        // Holding register occupied
  logic [7:0] sh_r, sh_nxt;            // Shift register
  logic [7:0] id_r, id_nxt;            // Copy of the identifier for retries
  logic [2:0] cnt_r, cnt_nxt;          // Bit counter
  logic       ifr_r, ifr_nxt;          // Current transfer is a response
  logic       eod_clr, rsp_clr;        // Hardware clears

  jvtx_crc_if crc_if ();

  // Submodules
  jvtx_crc8 u_crc (.pclk(pclk), .presetn(presetn), .crc(crc_if.unit));
  jvtx_rsp_prio u_prio (.pclk(pclk), .presetn(presetn), .rsp_raw(rsp_r), .rsp_eff(rsp_eff));

  // APB decode; zero wait states
  wire acc     = psel & penable;
  wire wr_ctrl = acc & pwrite & (paddr == `JVTX_CTRL_OFS);
  wire wr_data = acc & pwrite & (paddr == `JVTX_DATA_OFS);
  wire mapped  = (paddr == `JVTX_CTRL_OFS) | (paddr == `JVTX_DATA_OFS) |
                 (paddr == `JVTX_STAT_OFS);
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  // Response type decode
  wire single   = rsp_eff[`JVTX_RSP_SINGLE];
  wire mcrc     = rsp_eff[`JVTX_RSP_MCRC];
  wire rsp_any  = |rsp_eff;
  wire crc_need = ~ifr_r | mcrc;  // see (RULE18) (RULE19)
  // Single byte responses carry no CRC; format bit flips the polarity
  wire nb_val   = (mcrc ~^ norm_bit_format_select_r) ? 1'b0 : 1'b1;  // see (RULE3)

  // Symbol handshake and event decode
  wire take      = sym_valid & sym_ready;
  wire last_bit  = take & (cnt_r == `JVTX_CNT_LAST);
  wire busy      = (state_r != JVTX_IDLE);
  wire own_eod   = ifr_r & (state_r == JVTX_IDLE) & rx_eod_ok;

  // Outputs toward the symbol timer; nothing leaves in fast mode
  assign sym_valid = ~fast_r & ((state_r == JVTX_SOF) | (state_r == JVTX_NB) |  // see (RULE1)
                     (state_r == JVTX_SHIFT) | (state_r == JVTX_CRCB) |
                     (state_r == JVTX_EODS));
  assign sym_code  = (state_r == JVTX_SOF)  ? JVTX_SYM_SOF :
                     (state_r == JVTX_NB)   ? JVTX_SYM_NB  :
                     (state_r == JVTX_EODS) ? JVTX_SYM_EOD : JVTX_SYM_BIT;
  assign sym_bit   = (state_r == JVTX_NB) ? nb_val : sh_r[7];
  assign rate_fast = fast_r;  // see (RULE1) (RULE2)
  // Empty flag hidden once end of data is asked for
  assign tx_data_empty_flag = busy & ~full_r & ~eod_r;  // see (RULE6)

  // CRC unit control: preset when the SOF or NB symbol is taken
  assign crc_if.init = take & ((state_r == JVTX_SOF) | (state_r == JVTX_NB));
  assign crc_if.step = take & (state_r == JVTX_SHIFT);
  assign crc_if.din  = sh_r[7];

  // Read data
  always_comb begin
    prdata = 32'h0000_0000;
    if (acc & ~pwrite) begin
      if (paddr == `JVTX_CTRL_OFS)
        prdata[5:0] = {rsp_r, eod_r, norm_bit_format_select_r, fast_r};  // see (RULE10)
      else if (paddr == `JVTX_DATA_OFS)
        prdata[7:0] = hold_r;
      else if (paddr == `JVTX_STAT_OFS)
        prdata[6:0] = {state_r, ifr_r, full_r, busy, tx_data_empty_flag};
    end
  end

  // Sequencer next state and datapath
  always_comb begin
    state_nxt = state_r;
    sh_nxt    = sh_r;
    id_nxt    = id_r;
    cnt_nxt   = cnt_r;
    ifr_nxt   = ifr_r;
    eod_clr   = 1'b0;
    rsp_clr   = 1'b0;
    full_nxt  = full_r;
    unique case (state_r)
      JVTX_IDLE: begin
        if (own_eod) begin
          // Own response EOD echoed back: response complete
          eod_clr = 1'b1;  // see (RULE8)
          rsp_clr = 1'b1;
          ifr_nxt = 1'b0;
        end else if (~fast_r & rsp_any & rx_eod_ok) begin
          // Armed response starts after a good EOD
          state_nxt = JVTX_NB;  // see (RULE12) (RULE17)
          ifr_nxt   = 1'b1;
        end else if (~fast_r & full_r & ~rx_eod_ok) begin
          // Main message starts; no request means silence  see (RULE20)
          state_nxt = JVTX_SOF;  // see (RULE15)
          ifr_nxt   = 1'b0;
        end
      end
      JVTX_SOF: begin
        if (take) state_nxt = JVTX_LOAD;
      end
      JVTX_NB: begin
        // Another node's NB stands for ours  see (RULE13)
        if (take | rx_nb_seen) state_nxt = JVTX_LOAD;
      end
      JVTX_LOAD: begin
        cnt_nxt = `JVTX_CNT_RST;
        if (full_r) begin
          // Held byte always precedes the CRC  see (RULE5)
          sh_nxt    = hold_r;
          id_nxt    = hold_r;
          full_nxt  = 1'b0;
          state_nxt = JVTX_SHIFT;
        end else if (eod_r & crc_need) begin
          sh_nxt    = crc_if.crc_out;  // see (RULE4) (RULE18)
          state_nxt = JVTX_CRCB;
          eod_clr   = ~ifr_r;  // see (RULE7)
        end else if (eod_r) begin
          state_nxt = JVTX_EODS;  // see (RULE19)
        end else if (ifr_r) begin
          // Response underrun ends the response
          rsp_clr   = 1'b1;
          ifr_nxt   = 1'b0;
          state_nxt = JVTX_IDLE;
        end
      end
      JVTX_SHIFT, JVTX_CRCB: begin
        if (take) begin
          sh_nxt  = {sh_r[6:0], 1'b0};
          cnt_nxt = cnt_r + 3'h1;
        end
        if (last_bit && state_r == JVTX_CRCB) begin
          state_nxt = JVTX_EODS;
        end else if (last_bit && ifr_r && single) begin
          // Single byte response done: no EOD  see (RULE15)
          rsp_clr   = 1'b1;
          ifr_nxt   = 1'b0;
          state_nxt = JVTX_IDLE;
        end else if (last_bit) begin
          state_nxt = JVTX_LOAD;
        end
      end
      JVTX_EODS: begin
        if (take) state_nxt = JVTX_IDLE;  // see (RULE16)
      end
      JVTX_RETRY: begin
        if (rx_byte_valid && rx_byte == id_r) begin
          // Own identifier seen in the stream
          rsp_clr   = 1'b1;
          ifr_nxt   = 1'b0;
          state_nxt = JVTX_IDLE;
        end else if (rx_byte_valid) begin
          sh_nxt    = id_r;  // see (RULE14)
          cnt_nxt   = `JVTX_CNT_RST;
          state_nxt = JVTX_SHIFT;
        end
      end
    endcase
    // Arbitration loss: single byte retries, others give up
    if (arb_lost & busy & ~bus_error) begin
      if (ifr_r & single) begin
        state_nxt = JVTX_RETRY;  // see (RULE14)
      end else begin
        rsp_clr   = ifr_r;
        ifr_nxt   = 1'b0;
        state_nxt = JVTX_IDLE;
      end
    end
    // Bus error aborts the transfer and clears both requests
    if (bus_error) begin
      eod_clr   = 1'b1;  // see (RULE7) (RULE8)
      rsp_clr   = 1'b1;
      ifr_nxt   = 1'b0;
      state_nxt = JVTX_IDLE;
    end
    // Software write to the holding register wins over the load
    if (wr_data) full_nxt = 1'b1;
  end

  // Register writes; a software set wins over a hardware clear
  assign fast_nxt = wr_ctrl ? pwdata[`JVTX_C_FAST] : fast_r;
  assign norm_bit_format_select_nxt = wr_ctrl ? pwdata[`JVTX_C_NORM_BIT_FORMAT_SELECT] : norm_bit_format_select_r;
  assign eod_nxt  = (wr_ctrl & pwdata[`JVTX_C_EOD]) | (eod_r & ~eod_clr & ~wr_ctrl);
  assign rsp_nxt  = wr_ctrl ? pwdata[`JVTX_C_RSP_HI:`JVTX_C_RSP_LO] :
                    (rsp_clr ? `JVTX_RSP_RST : rsp_r);  // see (RULE10)
  assign hold_nxt = wr_data ? pwdata[7:0] : hold_r;

  // Control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_r <= 1'b0;
      norm_bit_format_select_r <= 1'b0;
      eod_r  <= 1'b0;
      rsp_r  <= `JVTX_RSP_RST;
      hold_r <= `JVTX_BYTE_RST;
      full_r <= 1'b0;
    end else begin
      fast_r <= fast_nxt;
      norm_bit_format_select_r <= norm_bit_format_select_nxt;
      eod_r  <= eod_nxt;
      rsp_r  <= rsp_nxt;
      hold_r <= hold_nxt;
      full_r <= full_nxt;
    end
  end

  // Sequencer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= JVTX_IDLE;
      sh_r    <= `JVTX_BYTE_RST;
      id_r    <= `JVTX_BYTE_RST;
      cnt_r   <= `JVTX_CNT_RST;
      ifr_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      sh_r    <= sh_nxt;
      id_r    <= id_nxt;
      cnt_r   <= cnt_nxt;
      ifr_r   <= ifr_nxt;
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_fast_silent: assert property (fast_r |-> !sym_valid) // see (RULE1)
    else $error("symbol requested in fast receive mode");
  a_rate_normal: assert property (!fast_r |-> !rate_fast) // see (RULE2)
    else $error("fast rate without fast select");
  a_nb_polarity: assert property (sym_valid && sym_code == JVTX_SYM_NB |-> // see (RULE3)
    sym_bit == (rsp_eff[`JVTX_RSP_MCRC] ? !norm_bit_format_select_r : norm_bit_format_select_r))
    else $error("normalization bit polarity wrong");
  a_crc_follows: assert property (state_r == JVTX_LOAD && !full_r && eod_r && !ifr_r // see (RULE4)
    && !bus_error && !arb_lost |=> state_r == JVTX_CRCB && cnt_r == 3'h0)
    else $error("CRC byte not started after end of data");
  a_held_first: assert property (state_r == JVTX_LOAD && full_r && !bus_error && !arb_lost // see (RULE5)
    |=> state_r == JVTX_SHIFT && sh_r == $past(hold_r))
    else $error("held byte not sent before CRC");
  a_tx_data_empty_flag_masked: assert property (eod_r |-> !tx_data_empty_flag) // see (RULE6)
    else $error("empty flag shown with end of data pending");
  a_eod_clr_main: assert property (state_r == JVTX_CRCB && !ifr_r && !$past(wr_ctrl) // see (RULE7)
    |-> !eod_r)
    else $error("end of data request kept during main CRC");
  a_eod_clr_ifr: assert property (own_eod && !wr_ctrl |=> !eod_r) // see (RULE8)
    else $error("end of data request kept after own EOD");
  a_readback: assert property (wr_ctrl ##3 (acc && !pwrite && paddr == `JVTX_CTRL_OFS) // see (RULE10)
    |-> prdata[5:3] == $past(pwdata[5:3], 3))
    else $error("response request readback differs from write");
  a_nocrc_plain: assert property (state_r == JVTX_CRCB |-> !ifr_r || mcrc) // see (RULE19)
    else $error("CRC sent on response without CRC");
endmodule // jvtx_tx_ctrl
`default_nettype wire

// [tb/jvtx_sym_model.sv]
// Stand-in for the symbol timer and bus: takes each requested symbol.
// Assumes the block's symbol handshake on the same clock as the bus.
`timescale 1ns/1ps
`default_nettype none
module jvtx_sym_model
  import jvtx_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         sym_valid,
  input  wire jvtx_sym_type sym_code,
  input  wire logic         sym_bit,
  input  wire logic [3:0]   delay,
  output logic              sym_ready
);
  logic [2:0] log_q[$];  // Symbols taken, code then bit
  logic [3:0] wait_r;    // Cycles the current symbol has stood

  // Take a symbol once it has stood for the delay, in the order offered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sym_ready <= 1'b0;
      wait_r    <= 4'h0;
    end else if (sym_valid && sym_ready) begin
      log_q.push_back({sym_code, sym_bit});
      sym_ready <= 1'b0;
      wait_r    <= 4'h0;
    end else if (sym_valid) begin               // Slow or prompt answer
      wait_r    <= wait_r + 4'h1;
      sym_ready <= (wait_r >= delay);
    end else begin                              // Withdrawn: drop handshake
      sym_ready <= 1'b0;
      wait_r    <= 4'h0;
    end
  end
endmodule // jvtx_sym_model
`default_nettype wire

// [tb/jvtx_tx_ctrl_tb.sv]
// Self-checking bench for the transmit and response control block.
// Assumes the symbol model stands in for the timer and the bus.
`timescale 1ns/1ps
`default_nettype none
`include "jvtx_map.svh"
module jvtx_tx_ctrl_tb
  import jvtx_pkg::*;
;
  logic         pclk, presetn, psel, penable, pwrite;  // Clock, reset, APB
  logic [7:0]   paddr;                                 // APB address
  logic [31:0]  pwdata, prdata, rdv;                   // APB data, last read
  logic         pready, pslverr, errv;                 // APB answer
  logic         sym_valid, sym_bit, sym_ready;         // Symbol link
  jvtx_sym_type sym_code;                              // Requested symbol
  logic         rx_eod_ok, rx_nb_seen, rx_byte_valid;  // Receiver events
  logic [7:0]   rx_byte;                               // Received byte
  logic         arb_lost, bus_error;                   // Bus faults
  logic         rate_fast, tx_data_empty_flag;         // Status outputs
  logic [3:0]   hold_cycles;                           // Model answer delay
  logic [2:0]   exp_q[$];                              // Expected symbols
  logic [7:0]   crc;                                   // Running CRC
  int           miscompares, samples_checked;          // Verdict counters

  jvtx_tx_ctrl jvtx_tx_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sym_valid(sym_valid),
    .sym_code(sym_code), .sym_bit(sym_bit), .sym_ready(sym_ready),
    .rx_eod_ok(rx_eod_ok), .rx_nb_seen(rx_nb_seen), .rx_byte_valid(rx_byte_valid),
    .rx_byte(rx_byte), .arb_lost(arb_lost), .bus_error(bus_error),
    .rate_fast(rate_fast), .tx_data_empty_flag(tx_data_empty_flag));

  jvtx_sym_model jvtx_sym_model_i (.pclk(pclk), .presetn(presetn),
    .sym_valid(sym_valid), .sym_code(sym_code), .sym_bit(sym_bit),
    .delay(hold_cycles), .sym_ready(sym_ready));

  // Free-running 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Prints the verdict and stops the run
  task automatic end_of_test;
    if (miscompares == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Compares one value and reports a difference
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; holds the request until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    // Answer is settled here and stands until the committing edge
    rdv  = prdata;
    errv = pslverr;
    @(posedge pclk);
    check("pready wait", n < 50, 1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // One-cycle receiver event: 0 EOD seen, 1 bus error, 2 byte seen
  task automatic strobe(input logic [1:0] w, input logic [7:0] b);
    rx_eod_ok     <= (w == 2'h0);
    bus_error     <= (w == 2'h1);
    rx_byte_valid <= (w == 2'h2);
    rx_byte       <= b;
    @(posedge pclk);
    rx_eod_ok     <= 1'b0;
    bus_error     <= 1'b0;
    rx_byte_valid <= 1'b0;
    @(posedge pclk);
  endtask

  // Reset pulse and fresh expectations
  task automatic reset_dut;
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    exp_q.delete();
    jvtx_sym_model_i.log_q.delete();
    crc = `JVTX_CRC_INIT;
  endtask

  // Expected symbols; a byte goes MSB first and feeds the CRC
  task automatic add_sym(input jvtx_sym_type c, input logic b);
    exp_q.push_back({c, b});
  endtask
  task automatic add_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      add_sym(JVTX_SYM_BIT, v[i]);
      crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ v[i]) ? `JVTX_CRC_POLY : 8'h00);
    end
  endtask

  // Counts cycles with a symbol requested
  task automatic count_valid(input int c, output int n);
    n = 0;
    repeat (c) begin
      @(posedge pclk);
      if (sym_valid !== 1'b0) n++;
    end
  endtask

  // Waits for the holding register to empty during a transfer
  task automatic wait_empty;
    int n;
    n = 0;
    while (tx_data_empty_flag !== 1'b1 && n < 500) begin
      @(posedge pclk);
      n++;
    end
    check("empty raised", tx_data_empty_flag, 1);
  endtask

  // Waits for the frame, lets it settle, compares every symbol taken
  task automatic settle(input logic single);
    int n;
    n = 0;
    while (jvtx_sym_model_i.log_q.size() < exp_q.size() && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    if (single) strobe(2'h2, 8'h96);
    repeat (40) @(posedge pclk);
    check("symbol count", jvtx_sym_model_i.log_q.size(), exp_q.size());
    foreach (exp_q[i]) begin
      if (exp_q[i][0] === 1'bx)
        check("symbol code", jvtx_sym_model_i.log_q[i][2:1], exp_q[i][2:1]);
      else
        check("symbol", jvtx_sym_model_i.log_q[i], exp_q[i]);
    end
  endtask

  // Reset state, unmapped access, silence after EOD without a request
  task automatic s_idle;
    int n;
    reset_dut;
    check("rate after reset", rate_fast, 0);
    apb(1'b0, `JVTX_CTRL_OFS, 32'h0000_0000);
    check("ctrl reset", rdv, 0);
    apb(1'b1, 8'h0c, 32'h0000_003f);
    check("unmapped error", errv, 1);
    apb(1'b0, `JVTX_CTRL_OFS, 32'h0000_0000);
    check("unmapped write", rdv, 0);
    strobe(2'h0, 8'h00);
    count_valid(40, n);
    check("no response", n, 0);
  endtask

  // Fast receive: nothing is ever sent
  task automatic s_fast;
    int n;
    reset_dut;
    apb(1'b1, `JVTX_CTRL_OFS, 32'h0000_0001);
    check("fast rate", rate_fast, 1);
    apb(1'b1, `JVTX_DATA_OFS, 32'h0000_005a);
    count_valid(60, n);
    check("fast silent", n, 0);
  endtask

  // Main message, one byte or with a held byte when EOD is asked
  task automatic s_main(input logic two);
    int n;
    reset_dut;
    hold_cycles <= 4'h3;
    check("normal rate", rate_fast, 0);
    apb(1'b1, `JVTX_DATA_OFS, 32'h0000_00a5);
    add_sym(JVTX_SYM_SOF, 1'bx);
    add_byte(8'ha5);
    wait_empty;
    if (two) begin
      apb(1'b1, `JVTX_DATA_OFS, 32'h0000_003c);
      add_byte(8'h3c);
    end
    apb(1'b1, `JVTX_CTRL_OFS, 32'h0000_0004);
    check("empty masked", tx_data_empty_flag, 0);
    apb(1'b0, `JVTX_CTRL_OFS, 32'h0000_0000);
    check("eod held", rdv[2], 1);
    add_byte(crc ^ `JVTX_CRC_XOR);
    add_sym(JVTX_SYM_EOD, 1'bx);
    n = 0;
    while (jvtx_sym_model_i.log_q.size() < 10 + 8 * two && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    apb(1'b0, `JVTX_CTRL_OFS, 32'h0000_0000);
    check("eod cleared at crc", rdv[2], 0);
    settle(1'b0);
  endtask

  // Bus error in mid-message drops the EOD request
  task automatic s_abort;
    reset_dut;
    hold_cycles <= 4'h5;
    apb(1'b1, `JVTX_DATA_OFS, 32'h0000_000f);
    apb(1'b1, `JVTX_CTRL_OFS, 32'h0000_0004);
    strobe(2'h1, 8'h00);
    apb(1'b0, `JVTX_CTRL_OFS, 32'h0000_0000);
    check("eod cleared by error", rdv[2], 0);
  endtask

  // In-frame response; kind 0 single, 1 with CRC, 2 without CRC
  task automatic s_rsp(input logic [2:0] rsp, input logic norm_bit_format_select, input logic nb,
                       input logic [1:0] kind);
    logic [31:0] cw;
    int n;
    reset_dut;
    hold_cycles <= 4'hf;
    cw = {26'h0, rsp, 1'b0, norm_bit_format_select, 1'b0};
    apb(1'b1, `JVTX_CTRL_OFS, cw);
    apb(1'b0, `JVTX_CTRL_OFS, 32'h0000_0000);
    check("request readback", rdv, cw);
    strobe(2'h0, 8'h00);
    n = 0;
    while (sym_valid !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    check("nb first", sym_code, JVTX_SYM_NB);
    check("nb value", sym_bit, nb);
    apb(1'b1, `JVTX_DATA_OFS, 32'h0000_0096);
    add_sym(JVTX_SYM_NB, nb);
    add_byte(8'h96);
    if (kind != 2'h0) begin
      wait_empty;
      apb(1'b1, `JVTX_CTRL_OFS, cw | 32'h0000_0004);
      if (kind == 2'h1) add_byte(crc ^ `JVTX_CRC_XOR);
      add_sym(JVTX_SYM_EOD, 1'bx);
    end
    settle(kind == 2'h0);
    if (kind != 2'h0) begin
      apb(1'b0, `JVTX_CTRL_OFS, 32'h0000_0000);
      check("eod kept", rdv[2], 1);
      strobe(2'h0, 8'h00);
      apb(1'b0, `JVTX_CTRL_OFS, 32'h0000_0000);
      check("eod released", rdv[2], 0);
    end
  endtask

  // Cuts a hang short
  initial begin
    repeat (40000) @(posedge pclk);
    miscompares++;
    end_of_test;
  end

  // Main sequence
  initial begin
    presetn       = 1'b0;
    psel          = 1'b0;
    penable       = 1'b0;
    pwrite        = 1'b0;
    paddr         = 8'h00;
    pwdata        = 32'h0000_0000;
    rx_eod_ok     = 1'b0;
    rx_nb_seen    = 1'b0;
    rx_byte_valid = 1'b0;
    rx_byte       = 8'h00;
    arb_lost      = 1'b0;
    bus_error     = 1'b0;
    hold_cycles   = 4'h2;
    @(posedge pclk);
    s_idle;
    s_fast;
    s_main(1'b0);
    s_main(1'b1);
    s_abort;
    s_rsp(3'b011, 1'b1, 1'b0, 2'h1);
    s_rsp(3'b001, 1'b1, 1'b1, 2'h2);
    s_rsp(3'b010, 1'b0, 1'b1, 2'h1);
    s_rsp(3'b001, 1'b0, 1'b0, 2'h2);
    s_rsp(3'b111, 1'b1, 1'b1, 2'h0);
    end_of_test;
  end
endmodule // jvtx_tx_ctrl_tb
`default_nettype wire
